// ### rtl/rtdfo_pkg.sv
// Package: register map, feature bits and format constants for the output formatter
package rtdfo_pkg;
    // Register indices on the 6-bit register address
    localparam logic [5:0] ADDR_MODE = 6'h20;
    localparam logic [5:0] ADDR_UOFS = 6'h21;
    localparam logic [5:0] ADDR_UGAIN = 6'h22;
    localparam logic [5:0] ADDR_FILT = 6'h25;
    localparam logic [5:0] ADDR_FOFS = 6'h13;
    localparam logic [5:0] ADDR_FGAIN = 6'h14;
    // Reset values
    localparam logic [15:0] RST_MODE = 16'h0106;
    localparam logic [15:0] RST_UOFS = 16'h0000;
    localparam logic [15:0] RST_UGAIN = 16'h0100;
    localparam logic [15:0] RST_FILT = 16'h0000;
    localparam logic [15:0] RST_FOFS = 16'h0000;
    localparam logic [15:0] RST_FGAIN = 16'h00a0;
    // Feature bit positions
    localparam int BIT_USER = 0;
    localparam int BIT_FACT = 1;
    localparam int BIT_WDOG = 2;
    localparam int BIT_SGNMAG = 3;
    localparam int BIT_STLOW = 4;
    localparam int BIT_FILT = 7;
    localparam int BIT_CLAMP = 8;
    localparam int BIT_TWOWIRE = 10;
    localparam int ELEM_LSB = 12;
    // Element codes
    localparam logic [3:0] ELEM_PT100 = 4'h0;
    localparam logic [3:0] ELEM_OHM5K = 4'he;
    localparam logic [3:0] ELEM_OHM1K2 = 4'hf;
    // Gain weighting is 2^-8
    localparam int GAIN_SHIFT = 8;
    // Clamp limit 850 degC in tenths, and in sixteenths
    localparam logic signed [15:0] LIM_TENTH = 16'sh2134;
    localparam logic signed [15:0] LIM_SIXTEENTH = 16'sh3520;
    // Filter constants and conversion times in ms
    localparam logic [15:0] FC_100HZ = 16'h0050;
    localparam logic [15:0] FC_50HZ = 16'h00a0;
    localparam logic [15:0] FC_25HZ = 16'h0140;
    localparam logic [15:0] FC_12HZ = 16'h0280;
    localparam int CONV_MS_25 = 250;
    localparam int CONV_MS_100 = 65;
    localparam int CONV_MS_50 = 125;
    localparam int CONV_MS_12 = 500;
    localparam int CLK_MHZ = 200;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
endpackage

// ### rtl/rtdfo_if.sv
// Interface: register values from the register file to the formatter
`timescale 1ns/10ps
interface rtdfo_if;
    logic [15:0] mode;
    logic [15:0] uofs;
    logic [15:0] ugain;
    logic [15:0] filt;
    logic [15:0] fofs;
    logic [15:0] fgain;
    modport regs (output mode, output uofs, output ugain, output filt, output fofs, output fgain);
    modport core (input mode, input uofs, input ugain, input filt, input fofs, input fgain);
endinterface

// ### rtl/rtdfo_regs.sv
// Channel register file: feature, scaling and filter registers
`timescale 1ns/10ps
module rtdfo_regs (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register access
    input wire logic wr_in,
    input wire logic [5:0] addr_in,
    input wire logic [15:0] wdata_in,
    output logic [15:0] rdata_out,
    output logic hit_out,
    // Register values
    rtdfo_if.regs rf
);
    logic [15:0] mode, uofs, ugain, filt, fofs, fgain, rdata;
    logic [15:0] next_mode, next_uofs, next_ugain, next_filt, next_fofs, next_fgain;
    logic [15:0] next_rdata;

    always_comb begin
        next_mode = mode;
        next_uofs = uofs;
        next_ugain = ugain;
        next_filt = filt;
        next_fofs = fofs;
        next_fgain = fgain;
        if (wr_in) begin
            case (addr_in)
                rtdfo_pkg::ADDR_MODE: begin
                    next_mode = wdata_in;
                end
                rtdfo_pkg::ADDR_UOFS: begin
                    next_uofs = wdata_in;
                end
                rtdfo_pkg::ADDR_UGAIN: begin
                    next_ugain = wdata_in;
                end
                rtdfo_pkg::ADDR_FILT: begin
                    next_filt = wdata_in;
                end
                rtdfo_pkg::ADDR_FOFS: begin
                    next_fofs = wdata_in;
                end
                rtdfo_pkg::ADDR_FGAIN: begin
                    next_fgain = wdata_in;
                end
                default: begin
                end
            endcase
        end
        case (addr_in)
            rtdfo_pkg::ADDR_MODE: next_rdata = mode;
            rtdfo_pkg::ADDR_UOFS: next_rdata = uofs;
            rtdfo_pkg::ADDR_UGAIN: next_rdata = ugain;
            rtdfo_pkg::ADDR_FILT: next_rdata = filt;
            rtdfo_pkg::ADDR_FOFS: next_rdata = fofs;
            rtdfo_pkg::ADDR_FGAIN: next_rdata = fgain;
            default: next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            // delivery value of the feature register
            mode <= rtdfo_pkg::RST_MODE;
            uofs <= rtdfo_pkg::RST_UOFS;
            ugain <= rtdfo_pkg::RST_UGAIN;
            filt <= rtdfo_pkg::RST_FILT;
            fofs <= rtdfo_pkg::RST_FOFS;
            fgain <= rtdfo_pkg::RST_FGAIN;
            rdata <= 16'h0000;
        end else begin
            mode <= next_mode;
            uofs <= next_uofs;
            ugain <= next_ugain;
            filt <= next_filt;
            fofs <= next_fofs;
            fgain <= next_fgain;
            rdata <= next_rdata;
        end
    end

    assign hit_out = (addr_in == rtdfo_pkg::ADDR_MODE) || (addr_in == rtdfo_pkg::ADDR_UOFS) ||
                     (addr_in == rtdfo_pkg::ADDR_UGAIN) || (addr_in == rtdfo_pkg::ADDR_FILT) ||
                     (addr_in == rtdfo_pkg::ADDR_FOFS) || (addr_in == rtdfo_pkg::ADDR_FGAIN);
    assign rdata_out = rdata;
    assign rf.mode = mode;
    assign rf.uofs = uofs;
    assign rf.ugain = ugain;
    assign rf.filt = filt;
    assign rf.fofs = fofs;
    assign rf.fgain = fgain;

    // reset leaves the documented feature value
    property p_mode_reset;
        @(posedge clk_in) rst_in |=> (mode == 16'h0106);
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("feature reset value wrong");
endmodule

// ### rtl/rtdfo_conv_timer.sv
// Conversion timer: pulses once per conversion period chosen by the filter constant
`timescale 1ns/10ps
module rtdfo_conv_timer #(
    parameter int CYC_PER_MS = rtdfo_pkg::CYC_PER_MS
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Period select in ms
    input wire logic [9:0] period_ms_in,
    // Conversion strobe
    output logic tick_out
);
    logic [17:0] cyc;
    logic [9:0] ms;
    logic tick;
    logic [17:0] next_cyc;
    logic [9:0] next_ms;
    logic next_tick;

    always_comb begin
        next_cyc = cyc + 18'h00001;
        next_ms = ms;
        next_tick = 1'b0;
        if (cyc >= 18'(CYC_PER_MS - 1)) begin
            next_cyc = 18'h00000;
            next_ms = ms + 10'h001;
            if (ms + 10'h001 >= period_ms_in) begin
                next_ms = 10'h000;
                next_tick = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cyc <= 18'h00000;
            ms <= 10'h000;
            tick <= 1'b0;
        end else begin
            cyc <= next_cyc;
            ms <= next_ms;
            tick <= next_tick;
        end
    end

    assign tick_out = tick;
endmodule

// ### rtl/rtdfo_top.sv
// Output formatter of one resistance-thermometer channel
//
// Summary of operation
// - Feature register resets to 0x0106.
// - Feature bit 0 applies user offset and gain.
// - Feature bit 1 applies factory offset and gain; set by default.
// - Feature bit 2 enables the channel watchdog; set by default.
// - Feature bit 3 gives sign-magnitude output, minus one is 0x8001.
// - Feature bit 4 puts status into the low three output bits.
// - Feature bit 7 uses the filter constant, else it is ignored.
// - Feature bit 8 clamps output at 850 degrees and flags overrange.
// - Factory scaling alone gives tenths of a degree or ohm.
// - No scaling gives sixteenths of a degree or ohm.
// - Status format puts value in bits 15..3, sign in 15.
// - Status format bit 0 overrange, bit 1 error, zero in range.
// - User offset is a signed 16-bit addend.
// - User gain is a signed 16-bit factor weighted 2^-8.
`timescale 1ns/10ps
module rtdfo_top #(
    parameter int CYC_PER_MS = rtdfo_pkg::CYC_PER_MS,
    parameter int WDOG_MS = 100
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic reg_wr_in,
    input wire logic [5:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_hit_out,
    // Measurement in sixteenths, from the compensation path
    input wire logic sample_valid_in,
    input wire logic signed [15:0] sample_in,
    input wire logic sample_err_in,
    // Process data activity for the watchdog
    input wire logic pd_activity_in,
    // Formatted output
    output logic [15:0] value_out,
    output logic valid_out,
    output logic [7:0] status_out,
    output logic convert_out,
    output logic wdog_expired_out,
    output logic two_wire_out,
    output logic [3:0] element_out,
    output logic ohms_mode_out
);
    rtdfo_if rf();
    logic [9:0] period_ms;
    logic conv_tick;

    rtdfo_regs u_regs (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .wr_in(reg_wr_in),
        .addr_in(reg_addr_in),
        .wdata_in(reg_wdata_in),
        .rdata_out(reg_rdata_out),
        .hit_out(reg_hit_out),
        .rf(rf.regs)
    );

    // ************************************************
    // Filter constant decode
    // ************************************************
    always_comb begin
        period_ms = 10'(rtdfo_pkg::CONV_MS_25);
        if (rf.mode[rtdfo_pkg::BIT_FILT]) begin
            case (rf.filt)
                rtdfo_pkg::FC_100HZ: period_ms = 10'(rtdfo_pkg::CONV_MS_100);
                rtdfo_pkg::FC_50HZ: period_ms = 10'(rtdfo_pkg::CONV_MS_50);
                rtdfo_pkg::FC_25HZ: period_ms = 10'(rtdfo_pkg::CONV_MS_25);
                rtdfo_pkg::FC_12HZ: period_ms = 10'(rtdfo_pkg::CONV_MS_12);
                default: period_ms = 10'(rtdfo_pkg::CONV_MS_25);
            endcase
        end
    end

    rtdfo_conv_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .period_ms_in(period_ms),
        .tick_out(conv_tick)
    );
    assign convert_out = conv_tick;

    // ************************************************
    // Scaling arithmetic
    // ************************************************
    // Straight line y = x * gain / 256 + offset, saturated to 16 bits
    function automatic logic signed [15:0] scale_line(input logic signed [15:0] x,
                                                      input logic signed [15:0] gain,
                                                      input logic signed [15:0] ofs);
        logic signed [31:0] prod;
        logic signed [31:0] sum;
        prod = x * gain;
        sum = (prod >>> rtdfo_pkg::GAIN_SHIFT) + 32'(ofs);
        if (sum > 32'sh00007fff) begin
            scale_line = 16'sh7fff;
        end else if (sum < -32'sh00008000) begin
            scale_line = -16'sh8000;
        end else begin
            scale_line = sum[15:0];
        end
    endfunction

    logic signed [15:0] fact_val, user_val, lim;
    logic signed [15:0] clamped;
    logic over, under;
    logic [15:0] coded;
    logic [15:0] next_value;
    logic [7:0] next_status;
    logic [15:0] value;
    logic [7:0] status;
    logic valid;

    always_comb begin
        fact_val = rf.mode[rtdfo_pkg::BIT_FACT] ?
                   scale_line(sample_in, rf.fgain, rf.fofs) : sample_in;
        // user line after the factory line
        user_val = rf.mode[rtdfo_pkg::BIT_USER] ?
                   scale_line(fact_val, rf.ugain, rf.uofs) : fact_val;
        lim = rf.mode[rtdfo_pkg::BIT_FACT] ? rtdfo_pkg::LIM_TENTH : rtdfo_pkg::LIM_SIXTEENTH;
        // Clamp applies to degree elements only; ohms ranges have no 850 limit
        over = 1'b0;
        under = 1'b0;
        clamped = user_val;
        if (rf.mode[rtdfo_pkg::BIT_CLAMP] && !ohms_mode_out && (fact_val > lim)) begin
            over = 1'b1;
            clamped = rf.mode[rtdfo_pkg::BIT_USER] ?
                      scale_line(lim, rf.ugain, rf.uofs) : lim;
        end
        if (rf.mode[rtdfo_pkg::BIT_SGNMAG] && clamped[15]) begin
            coded = {1'b1, 15'(-clamped)};
        end else begin
            coded = clamped;
        end
        next_value = coded;
        if (rf.mode[rtdfo_pkg::BIT_STLOW]) begin
            // bit 0 overrange, bit 1 error
            next_value = {coded[15], coded[14:3], 1'b0, sample_err_in, over | under};
        end
        next_status = {1'b0, sample_err_in, 4'h0, over, under};
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            value <= 16'h0000;
            status <= 8'h00;
            valid <= 1'b0;
        end else begin
            valid <= sample_valid_in;
            if (sample_valid_in) begin
                value <= next_value;
                status <= next_status;
            end
        end
    end

    assign value_out = value;
    assign valid_out = valid;
    assign status_out = status;

    // ************************************************
    // Watchdog and element select
    // ************************************************
    logic [31:0] wd_cnt, next_wd_cnt;
    logic wd_exp, next_wd_exp;

    always_comb begin
        next_wd_cnt = wd_cnt;
        next_wd_exp = wd_exp;
        if (!rf.mode[rtdfo_pkg::BIT_WDOG] || pd_activity_in) begin
            next_wd_cnt = 32'h0;
            next_wd_exp = 1'b0;
        end else if (wd_cnt >= 32'(WDOG_MS * CYC_PER_MS - 1)) begin
            next_wd_exp = 1'b1;
        end else begin
            next_wd_cnt = wd_cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wd_cnt <= 32'h0;
            wd_exp <= 1'b0;
        end else begin
            wd_cnt <= next_wd_cnt;
            wd_exp <= next_wd_exp;
        end
    end
    assign wdog_expired_out = wd_exp;

    assign two_wire_out = rf.mode[rtdfo_pkg::BIT_TWOWIRE];
    assign element_out = rf.mode[15:12];
    assign ohms_mode_out = (rf.mode[15:12] == rtdfo_pkg::ELEM_OHM5K) ||
                           (rf.mode[15:12] == rtdfo_pkg::ELEM_OHM1K2);

    // ************************************************
    // Checks
    // ************************************************
    property p_user_off;
        @(posedge clk_in) disable iff (rst_in)
        (sample_valid_in && !rf.mode[0] && !rf.mode[1] && !rf.mode[3] && !rf.mode[4]
         && !rf.mode[8]) |=> (value_out == $past(sample_in));
    endproperty
    a_user_off: assert property (p_user_off) else $error("unscaled value altered");

    property p_sgnmag;
        @(posedge clk_in) disable iff (rst_in)
        (sample_valid_in && rf.mode[4:0] == 5'b01100 && sample_in == -16'sd1)
        |=> (value_out == 16'h8001);
    endproperty
    a_sgnmag: assert property (p_sgnmag) else $error("sign-magnitude wrong");

    property p_stlow;
        @(posedge clk_in) disable iff (rst_in)
        (sample_valid_in && rf.mode[4]) |=> (value_out[1] == $past(sample_err_in));
    endproperty
    a_stlow: assert property (p_stlow) else $error("error bit wrong");

    property p_clamp;
        @(posedge clk_in) disable iff (rst_in)
        (sample_valid_in && rf.mode == 16'h0106 && sample_in > 16'sh3540)
        |=> (status_out[1] && value_out == 16'h2134);
    endproperty
    a_clamp: assert property (p_clamp) else $error("overrange clamp wrong");

    property p_wdog_off;
        @(posedge clk_in) disable iff (rst_in)
        !rf.mode[2] |=> !wdog_expired_out;
    endproperty
    a_wdog_off: assert property (p_wdog_off) else $error("watchdog ran while off");

    property p_filt_ign;
        @(posedge clk_in) disable iff (rst_in)
        !rf.mode[7] |-> (period_ms == 10'd250);
    endproperty
    a_filt_ign: assert property (p_filt_ign) else $error("filter not ignored");

    property p_filt_50;
        @(posedge clk_in) disable iff (rst_in)
        (rf.mode[7] && rf.filt == 16'h00a0) |-> (period_ms == 10'd125);
    endproperty
    a_filt_50: assert property (p_filt_50) else $error("filter period wrong");

    property p_ohms;
        @(posedge clk_in) disable iff (rst_in)
        (rf.mode[15:12] == 4'he) |-> ohms_mode_out;
    endproperty
    a_ohms: assert property (p_ohms) else $error("ohms mode decode wrong");

    property p_fact_tenth;
        @(posedge clk_in) disable iff (rst_in)
        (sample_valid_in && rf.mode[4:0] == 5'b00110 && rf.fgain == 16'h00a0
         && rf.fofs == 16'h0000 && sample_in == 16'sh0050) |=> (value_out == 16'h0032);
    endproperty
    a_fact_tenth: assert property (p_fact_tenth) else $error("factory tenths wrong");

    property p_user_ofs;
        @(posedge clk_in) disable iff (rst_in)
        (sample_valid_in && rf.mode[4:0] == 5'b00111 && rf.fgain == 16'h00a0
         && rf.fofs == 16'h0000 && rf.ugain == 16'h0100 && rf.uofs[15:8] == {8{rf.uofs[7]}}
         && sample_in == 16'sh0050) |=> (value_out == 16'h0032 + $past(rf.uofs));
    endproperty
    a_user_ofs: assert property (p_user_ofs) else $error("user offset wrong");

    property p_user_gain;
        @(posedge clk_in) disable iff (rst_in)
        (sample_valid_in && rf.mode[4:0] == 5'b00111 && rf.fgain == 16'h00a0
         && rf.fofs == 16'h0000 && rf.ugain == 16'h0200 && rf.uofs == 16'h0000
         && sample_in == 16'sh0050) |=> (value_out == 16'h0064);
    endproperty
    a_user_gain: assert property (p_user_gain) else $error("user gain wrong");

    property p_stlow_val;
        @(posedge clk_in) disable iff (rst_in)
        (sample_valid_in && rf.mode[4:0] == 5'b10100 && sample_in >= 16'sh0000
         && sample_in < 16'sh3520) |=> (value_out[15:3] == $past(sample_in[15:3]));
    endproperty
    a_stlow_val: assert property (p_stlow_val) else $error("status format value wrong");

    property p_stlow_ovr;
        @(posedge clk_in) disable iff (rst_in)
        (sample_valid_in && rf.mode[4:0] == 5'b10100 && rf.mode[8] && !ohms_mode_out
         && sample_in > 16'sh3520) |=> (value_out[0] && !value_out[2]);
    endproperty
    a_stlow_ovr: assert property (p_stlow_ovr) else $error("status format range bit wrong");

    property p_ohms_noclamp;
        @(posedge clk_in) disable iff (rst_in)
        (sample_valid_in && ohms_mode_out) |=> !status_out[1];
    endproperty
    a_ohms_noclamp: assert property (p_ohms_noclamp) else $error("ohms value clamped");
endmodule

// ### test/rtdfo_host_model.sv
// Controller-side model that reaches the channel registers
`timescale 1ns/10ps
module rtdfo_host_model (
    // Clock
    input wire logic clk_in,
    // Register port toward the channel
    output logic wr_out,
    output logic [5:0] addr_out,
    output logic [15:0] wdata_out,
    input wire logic [15:0] rdata_in
);
    initial begin
        wr_out = 1'b0;
        addr_out = 6'h00;
        wdata_out = 16'h0000;
    end

    // ********************************
    // Register cycles
    // ********************************
    task automatic write_reg(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk_in);
        addr_out = a;
        wdata_out = (a == rtdfo_pkg::ADDR_MODE) ? (d & 16'hf59f) : d;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        // Released data inverted, so a stale word never looks valid
        wdata_out = ~wdata_out;
    endtask

    // Address stays put after the read, so hit can still be looked at
    task automatic read_reg(input logic [5:0] a, output logic [15:0] d);
        @(negedge clk_in);
        addr_out = a;
        @(negedge clk_in);
        d = rdata_in;
    endtask
endmodule

// ### test/tb.sv
// Self-checking testbench for the channel output formatter
`timescale 1ns/10ps
module tb;
    typedef struct {logic [15:0] val; logic [15:0] mask; logic [7:0] st;} rtdfo_exp_s;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic reg_wr;
    logic [5:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic reg_hit;
    logic smp_valid = 1'b0;
    logic smp_err = 1'b0;
    logic pd_act = 1'b0;
    logic signed [15:0] smp = 16'sh0000;
    logic [15:0] value_out;
    logic valid_out;
    logic [7:0] status_out;
    logic convert;
    logic wdog;
    logic two_wire;
    logic ohms;
    logic [3:0] element;
    logic [31:0] seed = 32'hbd216eab;
    int n_mismatch = 0;
    int checks_done = 0;
    int k;
    int v;
    int n;
    rtdfo_exp_s expq[$];
    rtdfo_exp_s e;
    logic [5:0] amap [4] = '{6'h20, 6'h21, 6'h22, 6'h25};
    // Columns: mode, user offset, user gain, sample, expected, mask, status
    logic [15:0] tbl [13][7] = '{
        '{16'h0106, 16'h0000, 16'h0100, 16'h0050, 16'h0032, 16'hffff, 16'h0000},
        '{16'h0104, 16'h0000, 16'h0100, 16'h0050, 16'h0050, 16'hffff, 16'h0000},
        '{16'h0107, 16'h0064, 16'h0100, 16'h0050, 16'h0096, 16'hffff, 16'h0000},
        '{16'h0107, 16'h0000, 16'h0200, 16'h0050, 16'h0064, 16'hffff, 16'h0000},
        '{16'h0107, 16'hff9c, 16'h0100, 16'h0050, 16'hffce, 16'hffff, 16'h0000},
        '{16'h010c, 16'h0000, 16'h0100, 16'hffff, 16'h8001, 16'hffff, 16'h0000},
        '{16'h010c, 16'h0000, 16'h0100, 16'hfff0, 16'h8010, 16'hffff, 16'h0000},
        '{16'h0104, 16'h0000, 16'h0100, 16'h4000, 16'h3520, 16'hffff, 16'h0002},
        '{16'h0004, 16'h0000, 16'h0100, 16'h4000, 16'h4000, 16'hffff, 16'h0000},
        '{16'he106, 16'h0000, 16'h0100, 16'h3e80, 16'h2710, 16'hffff, 16'h0000},
        '{16'h0114, 16'h0000, 16'h0100, 16'h002d, 16'h0028, 16'hffff, 16'h0000},
        '{16'h0114, 16'h0000, 16'h0100, 16'h4000, 16'h0001, 16'h0007, 16'h0002},
        '{16'h0114, 16'h0000, 16'h0100, 16'h0005, 16'h0002, 16'h0007, 16'h0040}};
    // Filter code and conversion period in cycles at ten cycles per ms
    int ftbl [5][2] = '{'{0, 2500}, '{80, 650}, '{160, 1250}, '{320, 2500}, '{640, 5000}};

    initial begin
        forever #2.5 clk_in = ~clk_in;
    end

    // ********************************
    // Design and controller model
    // ********************************
    // Short ms and watchdog keep the run within budget
    rtdfo_top #(.CYC_PER_MS(10), .WDOG_MS(1)) dut (.clk_in(clk_in), .rst_in(rst_in),
        .reg_wr_in(reg_wr), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(reg_rdata), .reg_hit_out(reg_hit), .sample_valid_in(smp_valid),
        .sample_in(smp), .sample_err_in(smp_err), .pd_activity_in(pd_act),
        .value_out(value_out), .valid_out(valid_out), .status_out(status_out),
        .convert_out(convert), .wdog_expired_out(wdog), .two_wire_out(two_wire),
        .element_out(element), .ohms_mode_out(ohms));
    rtdfo_host_model host (.clk_in(clk_in), .wr_out(reg_wr), .addr_out(reg_addr),
        .wdata_out(reg_wdata), .rdata_in(reg_rdata));

    // ********************************
    // Helpers
    // ********************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic cmp16(input string what, input logic [15:0] ex, input logic [15:0] got);
        checks_done++;
        if (got !== ex) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, ex, got);
        end
    endtask

    task automatic chk_reg(input logic [5:0] a, input logic [15:0] ex, input logic h);
        logic [15:0] d;
        host.read_reg(a, d);
        cmp16("register", ex, d);
        cmp16("hit", {15'h0000, h}, {15'h0000, reg_hit});
    endtask

    task automatic send(input logic [15:0] x, input logic err, input logic [15:0] ev,
                        input logic [15:0] m, input logic [7:0] st);
        rtdfo_exp_s q;
        @(negedge clk_in);
        smp = x;
        smp_err = err;
        smp_valid = 1'b1;
        q.val = ev & m;
        q.mask = m;
        q.st = st;
        expq.push_back(q);
        @(negedge clk_in);
        smp_valid = 1'b0;
        smp = ~x;
    endtask

    // Bounded wait; returns cycles until the next conversion strobe
    task automatic wait_conv(output int c);
        c = 0;
        do begin
            @(negedge clk_in);
            c++;
        end while (convert !== 1'b1 && c < 6000);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ********************************
    // Output monitor
    // ********************************
    always @(negedge clk_in) begin
        if (valid_out === 1'b1) begin
            if (expq.size() == 0) begin
                n_mismatch++;
                $display("mismatch valid expected none seen %h", value_out);
            end else begin
                e = expq.pop_front();
                cmp16("value", e.val, value_out & e.mask);
                cmp16("status", {8'h00, e.st}, {8'h00, status_out});
            end
        end
    end

    // ********************************
    // Tests
    // ********************************
    initial begin
        repeat (20) @(negedge clk_in);
        rst_in = 1'b0;
        chk_reg(rtdfo_pkg::ADDR_MODE, 16'h0106, 1'b1);
        chk_reg(rtdfo_pkg::ADDR_FILT, 16'h0000, 1'b1);
        cmp16("mode pins", 16'h0000, {10'h000, two_wire, ohms, element});
        host.write_reg(6'h3f, 16'h1234);
        chk_reg(6'h3f, 16'h0000, 1'b0);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            host.write_reg(amap[i], seed[15:0]);
            chk_reg(amap[i], (i == 0) ? (seed[15:0] & 16'hf59f) : seed[15:0], 1'b1);
        end
        $display("test registers done");
        host.write_reg(rtdfo_pkg::ADDR_MODE, 16'h0106);
        host.write_reg(rtdfo_pkg::ADDR_UOFS, 16'h0000);
        host.write_reg(rtdfo_pkg::ADDR_UGAIN, 16'h0100);
        for (int i = 0; i < 64; i++) begin
            seed = xs(seed);
            pd_act = seed[31];
            k = int'(seed[15:0] % 16'd2400) - 400;
            v = (k * 5 > 8500) ? 8500 : k * 5;
            send(16'(k * 8), 1'b0, 16'(v), 16'hffff, (k * 5 > 8500) ? 8'h02 : 8'h00);
        end
        $display("test factory random done");
        for (int i = 0; i < 13; i++) begin
            host.write_reg(rtdfo_pkg::ADDR_MODE, tbl[i][0]);
            host.write_reg(rtdfo_pkg::ADDR_UOFS, tbl[i][1]);
            host.write_reg(rtdfo_pkg::ADDR_UGAIN, tbl[i][2]);
            send(tbl[i][3], tbl[i][6][6], tbl[i][4], tbl[i][5], tbl[i][6][7:0]);
        end
        host.write_reg(rtdfo_pkg::ADDR_MODE, 16'hf401);
        cmp16("mode pins", 16'h003f, {10'h000, two_wire, ohms, element});
        repeat (4) @(negedge clk_in);
        cmp16("queue left", 16'h0000, 16'(expq.size()));
        $display("test scaling and format done");
        pd_act = 1'b0;
        host.write_reg(rtdfo_pkg::ADDR_MODE, 16'h0106);
        repeat (40) @(negedge clk_in);
        cmp16("watchdog", 16'h0001, {15'h0000, wdog});
        rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        cmp16("watchdog", 16'h0000, {15'h0000, wdog});
        chk_reg(rtdfo_pkg::ADDR_MODE, 16'h0106, 1'b1);
        host.write_reg(rtdfo_pkg::ADDR_MODE, 16'h0102);
        repeat (40) @(negedge clk_in);
        cmp16("watchdog", 16'h0000, {15'h0000, wdog});
        $display("test watchdog done");
        host.write_reg(rtdfo_pkg::ADDR_FILT, 16'h0050);
        repeat (3) wait_conv(n);
        cmp16("period", 16'd2500, 16'(n));
        host.write_reg(rtdfo_pkg::ADDR_MODE, 16'h0186);
        for (int i = 0; i < 5; i++) begin
            host.write_reg(rtdfo_pkg::ADDR_FILT, 16'(ftbl[i][0]));
            repeat (3) wait_conv(n);
            cmp16("period", 16'(ftbl[i][1]), 16'(n));
        end
        $display("test filter done");
        tally_and_finish();
    end

    // Cut a hang short; the full run needs about 45000 cycles
    initial begin
        repeat (60000) @(posedge clk_in);
        n_mismatch++;
        $display("mismatch run length expected end seen timeout");
        tally_and_finish();
    end
endmodule
